// ### src/pcc_pkg.sv
// package: register map, field positions and types for one pwm channel
package pcc_pkg;
	localparam logic [1:0] ADDR_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_DUTY_HIGH = 2'h1;
	localparam logic [1:0] ADDR_DUTY_LOW = 2'h2;
	localparam int EN_BIT = 7;
	localparam int OUT_BIT = 5;
	localparam int POL_BIT = 4;
	localparam int DCL_HI = 7;
	localparam int DCL_LO = 6;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] DUTY_POWERUP = 8'h00;
	localparam logic [1:0] FRAC_LAST = 2'h3;
	typedef struct packed {
		logic en;
		logic pol;
	} pcc_ctrl_s;
	typedef struct packed {
		logic [7:0] high;
		logic [1:0] low;
	} pcc_duty_s;
endpackage : pcc_pkg

// ### src/pcc_channel.sv
// module: pwm channel control registers, duty buffer and output compare
// Summary of operation
// R1: polarity bit 4 inverts channel output
// R2: bit 5 reads output level, read-only
// R3: duty high byte gives eight msbs
// R4: duty low bits 7:6 give two lsbs
// R5: unimplemented bits read zero, writes dropped
// R6: control clears on reset; duty kept
// R7: channel runs only while enable set
// R8: set on timer clear, clear on match; code clears only for duty below {period_i, 2'h0}
// R9: duty at or above period: never clears
// R10: duty double-buffered, loaded on period match
// R11: zero duty keeps output inactive all period
`timescale 1ns/1ns
`default_nettype none
module pcc_channel (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic por_b_i,
	input wire logic [1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [7:0] timer_i,
	input wire logic [1:0] frac_i,
	input wire logic [7:0] period_i,
	output logic pwm_o
);
	pcc_pkg::pcc_ctrl_s ctrl, next_ctrl;
	pcc_pkg::pcc_duty_s duty, next_duty, act, next_act;
	logic level, next_level;
	logic [7:0] next_rdata;
	logic pwm_out, next_pwm_out;
	logic period_match;
	logic [9:0] base;

	// one cycle before the timer restarts: last sub-count at period value
	assign period_match = (timer_i == period_i) && (frac_i == pcc_pkg::FRAC_LAST);
	assign base = {timer_i, frac_i};

	always_comb begin
		next_ctrl = ctrl;
		next_duty = duty;
		if (wr_i) begin
			if (addr_i == pcc_pkg::ADDR_CONTROL) begin
				// bit 5 and unused bits are not stored
				next_ctrl.en = wdata_i[pcc_pkg::EN_BIT]; // R7
				next_ctrl.pol = wdata_i[pcc_pkg::POL_BIT]; // R1
			end else if (addr_i == pcc_pkg::ADDR_DUTY_HIGH) begin
				next_duty.high = wdata_i; // R3
			end else if (addr_i == pcc_pkg::ADDR_DUTY_LOW) begin
				next_duty.low = wdata_i[pcc_pkg::DCL_HI:pcc_pkg::DCL_LO]; // R4
			end
		end
	end

	// control cleared by ordinary reset (rst_b_i) only; power-on reset alone does not clear it
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl <= pcc_ctrl_reset(); // R6
		end else begin
			ctrl <= next_ctrl;
		end
	end

	function automatic pcc_pkg::pcc_ctrl_s pcc_ctrl_reset();
		pcc_ctrl_reset = '{en: pcc_pkg::CONTROL_RESET[pcc_pkg::EN_BIT],
			pol: pcc_pkg::CONTROL_RESET[pcc_pkg::POL_BIT]};
	endfunction : pcc_ctrl_reset

	// duty survives ordinary resets; only power-on clears it
	always_ff @(posedge ref_clk_i or negedge por_b_i) begin
		if (!por_b_i) begin
			duty <= {pcc_pkg::DUTY_POWERUP, 2'h0}; // R6
			act <= {pcc_pkg::DUTY_POWERUP, 2'h0};
		end else begin
			duty <= next_duty;
			act <= next_act;
		end
	end

	always_comb begin
		next_act = act;
		next_level = level;
		if (period_match) begin
			next_act = duty; // R10
		end
		if (!ctrl.en) begin
			next_level = 1'b0; // R7
		end else if (period_match) begin
			// restart with freshly loaded duty
			next_level = (duty != '0); // R8 R11
		end else if ((base + 10'h001) == act && act < {period_i, 2'h0} + 10'h000) begin
			next_level = 1'b0; // R8
		end else if (act >= {period_i, pcc_pkg::FRAC_LAST} + 10'h001) begin
			next_level = level; // R9
		end
		// enable and polarity taken from the same cycle so the pin never glitches on a write
		next_pwm_out = next_ctrl.en & (next_level ^ next_ctrl.pol); // R1 R7
		next_rdata = 8'h00; // R5
		if (rd_i) begin
			if (addr_i == pcc_pkg::ADDR_CONTROL) begin
				next_rdata[pcc_pkg::EN_BIT] = ctrl.en;
				next_rdata[pcc_pkg::OUT_BIT] = pwm_out; // R2
				next_rdata[pcc_pkg::POL_BIT] = ctrl.pol;
			end else if (addr_i == pcc_pkg::ADDR_DUTY_HIGH) begin
				next_rdata = duty.high; // R3
			end else if (addr_i == pcc_pkg::ADDR_DUTY_LOW) begin
				next_rdata[pcc_pkg::DCL_HI:pcc_pkg::DCL_LO] = duty.low; // R4 R5
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			level <= 1'b0;
			pwm_out <= 1'b0;
			rdata_o <= 8'h00;
		end else begin
			level <= next_level;
			pwm_out <= next_pwm_out;
			rdata_o <= next_rdata;
		end
	end

	assign pwm_o = pwm_out;

	property p_disabled_low;
		@(posedge ref_clk_i) disable iff (!rst_b_i) !ctrl.en |-> !pwm_out;
	endproperty
	a_disabled_low: assert property (p_disabled_low) else $error("output active while disabled"); // R7

	property p_polarity;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
			ctrl.en |-> pwm_out == (level ^ ctrl.pol);
	endproperty
	a_polarity: assert property (p_polarity) else $error("polarity mismatch"); // R1

	property p_load;
		@(posedge ref_clk_i) disable iff (!por_b_i) period_match |=> act == $past(duty);
	endproperty
	a_load: assert property (p_load) else $error("duty buffer not loaded"); // R10

	property p_hold;
		@(posedge ref_clk_i) disable iff (!por_b_i) !period_match |=> $stable(act);
	endproperty
	a_hold: assert property (p_hold) else $error("duty buffer changed mid period"); // R10

	property p_zero;
		@(posedge ref_clk_i) disable iff (!rst_b_i) period_match && duty == '0 |=> !level;
	endproperty
	a_zero: assert property (p_zero) else $error("zero duty went active"); // R11

	property p_start;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
			ctrl.en && period_match && duty != '0 |=> level;
	endproperty
	a_start: assert property (p_start) else $error("output not set at restart"); // R8

	property p_rd_ro;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
			rd_i && addr_i == pcc_pkg::ADDR_DUTY_LOW |=> rdata_o[5:0] == 6'h00;
	endproperty
	a_rd_ro: assert property (p_rd_ro) else $error("unimplemented bits nonzero"); // R5

	property p_rd_out;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
			rd_i && addr_i == pcc_pkg::ADDR_CONTROL |=> rdata_o[5] == $past(pwm_out);
	endproperty
	a_rd_out: assert property (p_rd_out) else $error("readback mismatch"); // R2

	property p_rd_idle;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
			!rd_i |=> rdata_o == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle"); // R5

	property p_rd_unmapped;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
			rd_i && addr_i == 2'h3 |=> rdata_o == 8'h00;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read nonzero"); // R5

	property p_rd_ctrl_bits;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
			rd_i && addr_i == pcc_pkg::ADDR_CONTROL |=> !rdata_o[6] && rdata_o[3:0] == 4'h0;
	endproperty
	a_rd_ctrl_bits: assert property (p_rd_ctrl_bits) else $error("control unused bits nonzero"); // R5

	property p_ctrl_write;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
			wr_i && addr_i == pcc_pkg::ADDR_CONTROL |=> ctrl.en == $past(wdata_i[7]) && ctrl.pol == $past(wdata_i[4]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost"); // R1 R7

	property p_high_write;
		@(posedge ref_clk_i) disable iff (!por_b_i)
			wr_i && addr_i == pcc_pkg::ADDR_DUTY_HIGH |=> duty.high == $past(wdata_i);
	endproperty
	a_high_write: assert property (p_high_write) else $error("duty high write lost"); // R3

	property p_low_write;
		@(posedge ref_clk_i) disable iff (!por_b_i)
			wr_i && addr_i == pcc_pkg::ADDR_DUTY_LOW |=> duty.low == $past(wdata_i[7:6]);
	endproperty
	a_low_write: assert property (p_low_write) else $error("duty low write lost"); // R4

	// duty at or past the period end: only a restart or a cleared enable may move the level
	property p_full;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
			ctrl.en && !period_match && act >= {period_i, 2'h0} |=> level == $past(level);
	endproperty
	a_full: assert property (p_full) else $error("full duty output cleared"); // R9

	property p_match_clear;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
			ctrl.en && !period_match && (base + 10'h001) == act && act < {period_i, 2'h0} |=> !level;
	endproperty
	a_match_clear: assert property (p_match_clear) else $error("output not cleared on match"); // R8

	c_restart: cover property (@(posedge ref_clk_i) ctrl.en && period_match && duty != '0);
	c_clear: cover property (@(posedge ref_clk_i) $fell(level) && ctrl.en && !period_match);
	c_inverted: cover property (@(posedge ref_clk_i) ctrl.en && ctrl.pol && pwm_out);
	c_full: cover property (@(posedge ref_clk_i) ctrl.en && period_match && act >= {period_i, 2'h0});
	c_zero: cover property (@(posedge ref_clk_i) ctrl.en && period_match && duty == '0);
endmodule : pcc_channel
`default_nettype wire

// ### tb/pcc_timer_model.sv
// shared period timer model feeding the channel's time base
`timescale 1ns/1ns
`default_nettype none
module pcc_timer_model (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] period_i,
	output logic [7:0] timer_o,
	output logic [1:0] frac_o
);
	// prescale 1:1, so the sub-count steps every clock
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			timer_o <= 8'h00;
			frac_o <= 2'h0;
		end else begin
			frac_o <= frac_o + 2'h1;
			if (frac_o == 2'h3)
				timer_o <= (timer_o == period_i) ? 8'h00 : timer_o + 8'h01;
		end
	end
endmodule : pcc_timer_model
`default_nettype wire

// ### tb/pcc_channel_bench.sv
// self-checking bench for the pwm channel
`timescale 1ns/1ns
`default_nettype none
module pcc_channel_bench;
	logic clk = 1'b0, rst_b = 1'b0, por_b = 1'b0, wr = 1'b0, rd = 1'b0, pwm;
	logic [1:0] addr = 2'h0, frac;
	logic [7:0] wdata = 8'h00, rdata, tmr, lfsr = 8'h59;
	logic [9:0] dl [4];
	int failures = 0, check_count = 0, cyc = 0, hi;
	always #2 clk = ~clk;
	pcc_timer_model pcc_timer_model_inst (.clk_i(clk), .rst_b_i(rst_b), .period_i(8'h09),
		.timer_o(tmr), .frac_o(frac));
	pcc_channel pcc_channel_inst (.ref_clk_i(clk), .rst_b_i(rst_b), .por_b_i(por_b),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.timer_i(tmr), .frac_i(frac), .period_i(8'h09), .pwm_o(pwm));
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr_next
	function automatic logic [9:0] exp_hi(input logic [9:0] d, input logic p);
		logic [9:0] w;
		w = (d > 10'd39) ? 10'd40 : d;
		return p ? 10'd40 - w : w;
	endfunction : exp_hi
	task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : cmp
	task automatic finish_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	// tasks drive strobes with nonblocking assignments at a rising edge, so the channel samples them one edge later
	task automatic wreg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		cmp({2'h0, rdata}, {2'h0, e});
	endtask : rreg
	task automatic measure(input logic [9:0] d, input logic p);
		wreg(2'h1, d[9:2]);
		wreg(2'h2, {d[1:0], 6'h3f});
		wreg(2'h0, {1'b1, 2'h0, p, 4'h0});
		repeat (80) @(posedge clk);
		hi = 0;
		repeat (40) begin
			@(negedge clk);
			hi += int'(pwm === 1'b1);
		end
		cmp(10'(hi), exp_hi(d, p));
		rreg(2'h1, d[9:2]);
		rreg(2'h2, {d[1:0], 6'h00});
		$display("test duty %h pol %b done", d, p);
	endtask : measure
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			finish_test();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		por_b <= 1'b1;
		rreg(2'h0, 8'h00);
		rreg(2'h3, 8'h00);
		wreg(2'h0, 8'h7f);
		rreg(2'h0, 8'h10);
		cmp({9'h0, pwm}, 10'h0);
		lfsr = lfsr_next(lfsr);
		dl = '{10'h0, 10'h1, 10'({2'h0, lfsr} % 35 + 1), 10'h3ff};
		for (int i = 0; i < 8; i++) begin
			measure(dl[i % 4], i[2]);
		end
		rreg(2'h0, 8'h90);
		@(posedge clk);
		rst_b <= 1'b0;
		@(posedge clk);
		rst_b <= 1'b1;
		rreg(2'h0, 8'h00);
		rreg(2'h1, 8'hff);
		finish_test();
	end
endmodule : pcc_channel_bench
`default_nettype wire
